// [design/cfg_mgr_map.vh]
// constants for the configuration manager: image slots, commands, timing
// assumes the includer is a design file on the 10 MHz system clock
`ifndef CFG_MGR_MAP_VH
`define CFG_MGR_MAP_VH
// number of flash image slots and slot index width
`define CM_IMAGE_SLOTS      4
`define CM_SLOT_W           2
// host command codes (3 bits)
`define CM_CMD_NONE         3'h0
`define CM_CMD_RELOAD       3'h1
`define CM_CMD_STREAM       3'h2
`define CM_CMD_FLASH_WRITE  3'h3
// source codes driven on the loader control output load_src_o
`define CM_SRC_FLASH        2'h0
`define CM_SRC_STREAM       2'h1
`define CM_SRC_JTAG         2'h2
// discovery window in microseconds and clock period in ns
`define CM_DISCOVERY_US     100000
`define CM_CLK_PERIOD_NS    100
// cycles allowed before the target must answer (round down)
`define CM_DISCOVERY_CYC    ((`CM_DISCOVERY_US * 1000) / `CM_CLK_PERIOD_NS)
// config-space header shadow depth in dwords
`define CM_CFG_WORDS        16
`define CM_CFG_AW           4
// dword index holding the device/vendor identity
`define CM_CFG_ID_IDX       4'h0
`endif

// [design/cfg_shadow_mem.v]
// config-space shadow memory: one write port, registered read port
// assumes single clock, writes and reads under the same enable
`timescale 1ns/100ps
module cfg_shadow_mem #(
  parameter DW = 32,  // word width
  parameter AW = 4    // address width
) (
  // clock and enable
  input  wire          clk_i,
  input  wire          ce_i,
  // write port
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  // read port
  input  wire [AW-1:0] raddr_i,
  output reg  [DW-1:0] rdata_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1]; // storage array

  ////////////////////////////////////////////////////////////////////////
  // write and registered read
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // cfg_shadow_mem

// [design/fpga_image_config_manager.v]
// configuration manager: keeps a config-space target alive while the
// logic loads from flash, a host stream or jtag.
// assumes cfg requests, host commands and loader handshakes are on clk_i;
// the image switch, jtag-active and load-done pins are asynchronous.
`timescale 1ns/100ps
`include "cfg_mgr_map.vh"

// Summary of operation
// - answer config accesses once the shadow init sweep after reset ends
// - flash holds four selectable image slots
// - power-up slot taken from hardware switch
// - host selects slot then reload command
// - host streamed image loads without flash
// - jtag may configure the logic directly
// - flash writable from jtag or host
// - config space shadow survives every reload
// - same device identity before and after
module fpga_image_config_manager #(
  parameter DISCOVERY_CYC = `CM_DISCOVERY_CYC, // discovery window in cycles
  parameter [31:0] DEVICE_ID = 32'h5A5A_0001   // identity, value arbitrary
) (
  // clock, reset, enable
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        ce_i,
  // asynchronous pins
  input  wire [1:0]  image_switch_i,
  input  wire        jtag_active_i,
  input  wire        load_done_i,
  // host config-space accesses
  input  wire        cfg_req_i,
  input  wire        cfg_wr_i,
  input  wire [3:0]  cfg_addr_i,
  input  wire [31:0] cfg_wdata_i,
  output reg         cfg_ack_o,
  output reg  [31:0] cfg_rdata_o,
  output reg         cfg_fwd_o,
  // host commands
  input  wire        cmd_valid_i,
  input  wire [2:0]  cmd_code_i,
  input  wire [1:0]  cmd_slot_i,
  // loader control
  output reg         load_start_o,
  output reg  [1:0]  load_slot_o,
  output reg  [1:0]  load_src_o,
  output reg         flash_wr_en_o,
  output reg         flash_wr_jtag_o,
  // status
  output reg         busy_o,
  output reg         user_ready_o,
  output reg         discovery_late_o
);
  // one-hot states
  localparam [4:0] ST_STRAP = 5'h01, ST_LOAD = 5'h02, ST_RUN = 5'h04,
                   ST_FLWR = 5'h08, ST_JTAG = 5'h10;

  reg [4:0]  state;        // controller state
  reg [1:0]  sw_s1, sw_s2; // switch synchroniser
  reg [1:0]  jt_sync;      // jtag-active synchroniser
  reg [1:0]  dn_sync;      // load-done synchroniser
  reg        wipe_done;    // shadow initialised
  reg [3:0]  wipe_addr;    // init pointer
  reg [31:0] disc_cnt;     // discovery watchdog
  reg        done_q;       // load-done, one cycle older
  reg        req_q;        // accepted request, one cycle older
  reg [3:0]  addr_q;       // dword index of that request
  wire       jtag_s = jt_sync[1];
  wire       done_s = dn_sync[1];
  wire       done_rise = done_s && !done_q; // fresh completion only
  wire [31:0] shadow_q;    // shadow read data

  // identity word is read-only in the shadow
  function is_id_word;
    input [3:0] a;
    is_id_word = (a == `CM_CFG_ID_IDX);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sw_s1   <= 2'h0;
      sw_s2   <= 2'h0;
      jt_sync <= 2'h0;
      dn_sync <= 2'h0;
      done_q  <= 1'b0;
    end else if (ce_i) begin
      sw_s1   <= image_switch_i;
      sw_s2   <= sw_s1;
      jt_sync <= {jt_sync[0], jtag_active_i};
      dn_sync <= {dn_sync[0], load_done_i};
      done_q  <= dn_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // config shadow: keeps the header across reloads
  wire        sh_we    = !wipe_done ? 1'b1 :
                         (cfg_req_i && cfg_wr_i && !is_id_word(cfg_addr_i));
  wire [3:0]  sh_waddr = !wipe_done ? wipe_addr : cfg_addr_i;
  wire [31:0] sh_wdata = !wipe_done ?
                         (is_id_word(wipe_addr) ? DEVICE_ID : 32'h0000_0000) :
                         cfg_wdata_i;

  cfg_shadow_mem #(.DW(32), .AW(`CM_CFG_AW)) u_shadow (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (sh_we),
    .waddr_i (sh_waddr),
    .wdata_i (sh_wdata),
    .raddr_i (cfg_addr_i),
    .rdata_o (shadow_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // shadow init sweep after reset
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wipe_done <= 1'b0;
      wipe_addr <= 4'h0;
    end else if (ce_i && !wipe_done) begin
      wipe_addr <= wipe_addr + 4'h1;
      if (wipe_addr == 4'hF) begin
        wipe_done <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // config access answers: ack two cycles after the request, since the
  // shadow read port is registered and its data settle one cycle late
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_q       <= 1'b0;
      addr_q      <= 4'h0;
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      req_q     <= cfg_req_i && wipe_done;
      addr_q    <= cfg_addr_i;
      cfg_ack_o <= req_q;
      if (is_id_word(addr_q)) begin
        cfg_rdata_o <= DEVICE_ID;
      end else begin
        cfg_rdata_o <= shadow_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // discovery watchdog: flags if init overran the window
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      disc_cnt         <= 32'h0000_0000;
      discovery_late_o <= 1'b0;
    end else if (ce_i && !wipe_done) begin
      disc_cnt <= disc_cnt + 32'h0000_0001;
      if (disc_cnt >= DISCOVERY_CYC - 1) begin
        discovery_late_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // load controller
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state           <= ST_STRAP;
      load_start_o    <= 1'b0;
      load_slot_o     <= 2'h0;
      load_src_o      <= `CM_SRC_FLASH;
      flash_wr_en_o   <= 1'b0;
      flash_wr_jtag_o <= 1'b0;
      busy_o          <= 1'b1;
      user_ready_o    <= 1'b0;
      cfg_fwd_o       <= 1'b0;
    end else if (ce_i) begin
      load_start_o <= 1'b0;
      case (state)
        ST_STRAP: begin
          if (wipe_done) begin
            load_slot_o  <= sw_s2;
            load_src_o   <= `CM_SRC_FLASH;
            load_start_o <= 1'b1;
            state        <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          cfg_fwd_o    <= 1'b0;
          user_ready_o <= 1'b0;
          busy_o       <= 1'b1;
          // only a rise counts: done stays high from the last load
          if (done_rise) begin
            state        <= ST_RUN;
            busy_o       <= 1'b0;
            user_ready_o <= 1'b1;
            cfg_fwd_o    <= 1'b1;
          end
        end
        ST_RUN: begin
          if (jtag_s) begin
            state        <= ST_JTAG;
            load_src_o   <= `CM_SRC_JTAG;
            busy_o       <= 1'b1;
            user_ready_o <= 1'b0;
            cfg_fwd_o    <= 1'b0;
          end else if (cmd_valid_i && cmd_code_i == `CM_CMD_RELOAD) begin
            load_slot_o  <= cmd_slot_i;
            load_src_o   <= `CM_SRC_FLASH;
            load_start_o <= 1'b1;
            busy_o       <= 1'b1;
            user_ready_o <= 1'b0;
            cfg_fwd_o    <= 1'b0;
            state        <= ST_LOAD;
          end else if (cmd_valid_i && cmd_code_i == `CM_CMD_STREAM) begin
            load_src_o   <= `CM_SRC_STREAM;
            load_start_o <= 1'b1;
            busy_o       <= 1'b1;
            user_ready_o <= 1'b0;
            cfg_fwd_o    <= 1'b0;
            state        <= ST_LOAD;
          end else if (cmd_valid_i && cmd_code_i == `CM_CMD_FLASH_WRITE) begin
            load_slot_o     <= cmd_slot_i;
            flash_wr_en_o   <= 1'b1;
            flash_wr_jtag_o <= 1'b0;
            busy_o          <= 1'b1;
            state           <= ST_FLWR;
          end
        end
        ST_FLWR: begin
          // write ends on a fresh loader done
          if (done_rise) begin
            flash_wr_en_o <= 1'b0;
            busy_o        <= 1'b0;
            state         <= ST_RUN;
          end
        end
        ST_JTAG: begin
          flash_wr_jtag_o <= 1'b1;
          if (!jtag_s) begin
            flash_wr_jtag_o <= 1'b0;
            state           <= ST_LOAD;
          end
        end
        default: begin
          state <= ST_STRAP;
        end
      endcase
    end
  end
endmodule // fpga_image_config_manager

// [testbench/cfg_loader_model.sv]
// far-side loader model: answers loads and flash writes with done
// assumes manager requests are synchronous to clk_i
`timescale 1ns/100ps
module cfg_loader_model (
  // clock and requests
  input  wire       clk_i,
  input  wire       load_start_i,
  input  wire       flash_wr_en_i,
  input  wire       jtag_i,
  input  wire [3:0] delay_i,
  // completion level
  output reg        load_done_o
);
  reg [4:0] cnt;  // cycles left
  reg       wr_q; // last flash write enable
  reg       jt_q; // last jtag-active level
  initial begin
    load_done_o = 1'b0;
    cnt = 5'h0;
    wr_q = 1'b0;
    jt_q = 1'b0;
  end
  // done after a variable load time
  always @(posedge clk_i) begin
    wr_q <= flash_wr_en_i;
    jt_q <= jtag_i;
    if (load_start_i || (flash_wr_en_i && !wr_q) || (jt_q && !jtag_i)) begin
      load_done_o <= 1'b0;
      cnt <= {1'b0, delay_i} + 5'h2;
    end else if (jtag_i) begin
      // logic held unconfigured while the programmer owns it
      load_done_o <= 1'b0;
      cnt <= 5'h0;
    end else if (cnt == 5'h1) begin
      load_done_o <= 1'b1;
      cnt <= 5'h0;
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
    end
  end
endmodule // cfg_loader_model

// [testbench/fpga_image_config_manager_asserts.sv]
// checker on the manager ports: answers, loads, identity
// assumes bind into the manager top, one clock domain
`timescale 1ns/100ps
module cfg_mgr_asserts #(
  parameter [31:0] DEVICE_ID = 32'h0
) (
  // clock, reset, requests
  input wire        clk_i, reset_n_i, ce_i, cfg_req_i, cfg_wr_i, cmd_valid_i,
  input wire [3:0]  cfg_addr_i,
  input wire [2:0]  cmd_code_i,
  input wire [1:0]  cmd_slot_i, load_slot_o, load_src_o,
  // answers
  input wire        cfg_ack_o, cfg_fwd_o, load_start_o, flash_wr_en_o,
  input wire        busy_o, user_ready_o, discovery_late_o,
  input wire [31:0] cfg_rdata_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire run_cmd = cmd_valid_i && ce_i && user_ready_o && !busy_o; // command accepted
  chk_ack_cause: assert property (cfg_ack_o |-> $past(cfg_req_i && ce_i, 2))
    else $error("ack without request");
  chk_id_read: assert property (cfg_ack_o && $past(cfg_addr_i, 2) == 4'h0 &&
    !$past(cfg_wr_i, 2) |-> cfg_rdata_o == DEVICE_ID) else $error("identity changed");
  chk_fwd_off: assert property ($rose(busy_o) && !flash_wr_en_o |=> !cfg_fwd_o)
    else $error("forwarding during reload");
  chk_flash_live: assert property ($rose(flash_wr_en_o) |-> cfg_fwd_o && user_ready_o)
    else $error("user logic dropped during flash write");
  chk_start_busy: assert property (load_start_o |-> busy_o && !$past(load_start_o))
    else $error("load start not a busy pulse");
  chk_reload_go: assert property (run_cmd && cmd_code_i == 3'h1 |=> load_start_o &&
    load_src_o == 2'h0 && load_slot_o == $past(cmd_slot_i)) else $error("reload lost");
  chk_stream_go: assert property (run_cmd && cmd_code_i == 3'h2 |=>
    load_start_o && load_src_o == 2'h1) else $error("stream load lost");
  chk_flash_wr: assert property (run_cmd && cmd_code_i == 3'h3 |=>
    flash_wr_en_o && busy_o) else $error("flash write lost");
  chk_run_state: assert property ($rose(user_ready_o) |-> cfg_fwd_o && !busy_o)
    else $error("run state mismatch");
  chk_no_late: assert property (!discovery_late_o)
    else $error("discovery window missed");
endmodule // cfg_mgr_asserts

// [testbench/tb_fpga_image_config_manager.sv]
// bench for the configuration manager with a loader model
// assumes the design header is on the include path
`timescale 1ns/100ps
module tb_fpga_image_config_manager;
  localparam [31:0] DEV = 32'h5A5A_0001; // identity, value arbitrary
  logic        clk_i = 0, reset_n_i = 0, jtag = 0, req = 0, wr = 0, vld = 0;
  logic [1:0]  sw = 0, slot = 0, exp_slot = 0; // exp_slot: slot the loader should hold
  logic [3:0]  addr = 0, dly = 3;
  logic [2:0]  code = 0;
  logic [31:0] wdata = 0;
  wire         done, ack, fwd, start, fwe, fwj, busy, rdy, late;
  wire [31:0]  rdata;
  wire [1:0]   lslot, lsrc;
  logic [31:0] shadow [0:15]; // model of config space
  integer      err_total = 0, comparisons = 0, cyc = 0, i, a;
  fpga_image_config_manager #(.DISCOVERY_CYC(20), .DEVICE_ID(DEV)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .image_switch_i(sw),
    .jtag_active_i(jtag), .load_done_i(done), .cfg_req_i(req), .cfg_wr_i(wr),
    .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_ack_o(ack), .cfg_rdata_o(rdata),
    .cfg_fwd_o(fwd), .cmd_valid_i(vld), .cmd_code_i(code), .cmd_slot_i(slot),
    .load_start_o(start), .load_slot_o(lslot), .load_src_o(lsrc),
    .flash_wr_en_o(fwe), .flash_wr_jtag_o(fwj), .busy_o(busy),
    .user_ready_o(rdy), .discovery_late_o(late));
  cfg_loader_model model (.clk_i(clk_i), .load_start_i(start),
    .flash_wr_en_i(fwe), .jtag_i(jtag), .delay_i(dly), .load_done_o(done));
  always #50 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  task chk(input string nm, input logic [31:0] seen, exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one config access, answered two cycles later
  task cfg(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    req <= 1;
    wr <= w;
    addr <= ad;
    wdata <= d;
    @(posedge clk_i);
    req <= 0;
    // ack stands one cycle, two edges after the request edge
    @(posedge clk_i);
    #1;
    chk("ack", ack, 1);
    if (w && ad != 0) shadow[ad] = d;
    if (!w) chk("rdata", rdata, shadow[ad]);
  endtask
  task wait_rdy;
    for (i = 0; (rdy !== 1'b1 || busy !== 1'b0) && i < 200; i = i + 1) @(posedge clk_i) #1;
    chk("ready", rdy, 1);
    chk("idle", busy, 0);
    chk("fwd run", fwd, 1);
  endtask
  task cmd(input logic [2:0] c, input logic [1:0] s);
    @(posedge clk_i);
    vld <= 1;
    code <= c;
    slot <= s;
    dly <= 4'($urandom % 10);
    @(posedge clk_i);
    vld <= 0;
    #1;
    // a stream load leaves the slot as it was
    if (c != 3'h2) exp_slot = s;
    chk("busy", busy, 1);
    chk("slot", lslot, exp_slot);
    chk("start", start, c != 3'h3);
    if (c == 3'h3) chk("flash wr", fwe, 1);
    else chk("src", lsrc, c - 3'h1);
    cfg(0, 0, 0); // answered during the reload, stream load or flash write
    // a flash write leaves the user logic running
    chk("fwd", fwd, c == 3'h3);
    wait_rdy;
  endtask
  // reset, refused early access, strap load
  task boot(input logic [1:0] s);
    @(posedge clk_i);
    reset_n_i <= 0;
    sw <= s;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1;
    for (i = 1; i < 16; i = i + 1) shadow[i] = 0; // reset wipes the header
    shadow[0] = DEV;
    exp_slot = s;
    req <= 1;
    addr <= 0;
    wr <= 0;
    @(posedge clk_i);
    req <= 0;
    // an accepted request would show its ack at this edge
    @(posedge clk_i);
    #1;
    chk("refused", ack, 0);
    for (i = 0; start !== 1'b1 && i < 40; i = i + 1) @(posedge clk_i) #1;
    chk("boot slot", lslot, s);
    chk("boot src", lsrc, 0);
    cfg(0, 0, 0);
    wait_rdy;
  endtask
  initial begin
    void'($urandom(32'h30079FF9));
    boot(2'($urandom));
    for (a = 1; a < 16; a = a + 1) cfg(1, a[3:0], $urandom);
    cfg(1, 0, 32'hFFFF_FFFF);
    for (a = 0; a < 4; a = a + 1) cmd(1, a[1:0] ^ sw);
    cmd(2, 0);
    cmd(3, 2'($urandom));
    for (a = 0; a < 16; a = a + 1) cfg(0, a[3:0], 0);
    @(posedge clk_i);
    jtag <= 1;
    for (i = 0; fwj !== 1'b1 && i < 20; i = i + 1) @(posedge clk_i) #1;
    chk("jtag", fwj, 1);
    chk("jtag src", lsrc, 2);
    chk("jtag fwd", fwd, 0);
    cfg(0, 0, 0);
    @(posedge clk_i);
    jtag <= 0;
    wait_rdy;
    chk("jtag off", fwj, 0);
    boot(~sw);
    chk("late", late, 0);
    wrap_up;
  end
endmodule // tb_fpga_image_config_manager
bind fpga_image_config_manager cfg_mgr_asserts #(.DEVICE_ID(DEVICE_ID)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .cfg_req_i(cfg_req_i),
  .cfg_wr_i(cfg_wr_i), .cmd_valid_i(cmd_valid_i), .cfg_addr_i(cfg_addr_i),
  .cmd_code_i(cmd_code_i), .cmd_slot_i(cmd_slot_i), .load_slot_o(load_slot_o),
  .load_src_o(load_src_o), .cfg_ack_o(cfg_ack_o), .cfg_fwd_o(cfg_fwd_o),
  .load_start_o(load_start_o), .flash_wr_en_o(flash_wr_en_o), .busy_o(busy_o),
  .user_ready_o(user_ready_o), .discovery_late_o(discovery_late_o),
  .cfg_rdata_o(cfg_rdata_o));
